/* logic/fca_alu.sv */
// fixed-point arithmetic unit: all short and long primitives, one cycle latency
// assumes requests come from logic on mclk; no state is kept between operations
`timescale 1ns/1ps
`default_nettype none

// Function
// - operands are signed 16-bit short and signed 32-bit long words
// - shift left fills zeros; negative count shifts right arithmetically
// - shift right extends sign; negative count shifts left with zero fill
// - short sum saturates to +32767 or -32768
// - short difference saturates to +32767 or -32768
// - scaled product is product shifted right 15; min times min gives 32767
// - rounded product adds 16384 before shifting; min times min gives 32767
// - magnitude of short; most negative input gives 32767
// - divide needs 0 < dividend <= divisor; truncated positive quotient, equal gives 32767
// - widening multiply is product shifted left one into 32 bits
// - long sum saturates to 2147483647 or -2147483648
// - long difference saturates to 2147483647 or -2147483648
// - shift count brings a long into the normalised positive or negative range
// - short to long places bits low and sign-extends the upper half
// - long to short keeps lowest 16 bits, no saturation
// - a constant operand of a long operation is sign-extended to 32 bits
// - samples keep upper 13 bits; parameters keep their low valid bits
module fca_alu
    import fca_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire fca_req_t req,
    output fca_rsp_t rsp
);

    fca_rsp_t next_rsp;
    logic [16:0] sum_s;
    logic [16:0] dif_s;
    logic [32:0] sum_l;
    logic [32:0] dif_l;
    logic [31:0] b_eff;
    logic signed [31:0] prod;
    logic [31:0] prod_r;
    logic both_min;
    logic [15:0] quo;
    logic div_bad;
    logic [15:0] norm_cnt;
    logic [15:0] par_mask;

    // shift of a short by a signed count
    function automatic logic [15:0] sh16(input logic [15:0] x, input logic [15:0] n,
                                         input logic left);
        logic go_left;
        logic [15:0] mag;
        go_left = left ^ n[15];
        mag = n[15] ? 16'(~n + 16'h0001) : n;
        if (go_left)
            sh16 = (mag >= SH_LIM_S) ? 16'h0000 : 16'(x << mag[3:0]);
        else
            sh16 = (mag >= SH_LIM_S) ? {16{x[15]}} : 16'($signed(x) >>> mag[3:0]);
    endfunction

    // shift of a long by a signed count
    function automatic logic [31:0] sh32(input logic [31:0] x, input logic [15:0] n,
                                         input logic left);
        logic go_left;
        logic [15:0] mag;
        go_left = left ^ n[15];
        mag = n[15] ? 16'(~n + 16'h0001) : n;
        if (go_left)
            sh32 = (mag >= SH_LIM_L) ? 32'h00000000 : 32'(x << mag[4:0]);
        else
            sh32 = (mag >= SH_LIM_L) ? {32{x[31]}} : 32'($signed(x) >>> mag[4:0]);
    endfunction

    // saturating adders and subtractors, one guard bit each
    assign sum_s = {req.a_s[15], req.a_s} + {req.b_s[15], req.b_s};
    assign dif_s = {req.a_s[15], req.a_s} - {req.b_s[15], req.b_s};
    assign b_eff = req.b_const ? {{16{req.b_s[15]}}, req.b_s} : req.b_l;
    assign sum_l = {req.a_l[31], req.a_l} + {b_eff[31], b_eff};
    assign dif_l = {req.a_l[31], req.a_l} - {b_eff[31], b_eff};

    // full signed product of two shorts
    assign prod = $signed(req.a_s) * $signed(req.b_s);
    assign prod_r = 32'(prod) + MULT_RND;
    assign both_min = (req.a_s == S_MIN) && (req.b_s == S_MIN);
    assign par_mask = 16'((16'h0001 << req.param_w) - 16'h0001);

    fca_div u_div (
        .num(req.a_s),
        .den(req.b_s),
        .quo(quo),
        .bad(div_bad)
    );

    // normalisation count: leading bits equal to the sign, less one; a negative operand other than -2^31 is
    // scanned one below itself, since the negative window closes on -2^30 itself
    always_comb
    begin
        logic found;
        logic [31:0] src;
        found = 1'b0;
        src = req.a_l;
        if (req.a_l[31] && (req.a_l != L_MIN))
            src = 32'(req.a_l - 32'h00000001);
        norm_cnt = 16'h0000;
        if (req.a_l == 32'h00000000)
            norm_cnt = 16'h0000;
        else
        begin
            norm_cnt = NORM_TOP + 16'h0001;
            for (int i = 30; i >= 0; i--)
            begin
                if (!found && (src[i] != src[31]))
                begin
                    found = 1'b1;
                    norm_cnt = 16'(30 - i);
                end
            end
        end
    end

    // next answer from the current request
    always_comb
    begin
        next_rsp = '0;
        next_rsp.valid = req.valid;
        next_rsp.op = req.op;
        case (req.op)
            OP_ADD:
            begin
                next_rsp.sat = sum_s[16] ^ sum_s[15];
                next_rsp.res_s = next_rsp.sat ? (sum_s[16] ? S_MIN : S_MAX)
                                              : sum_s[15:0];
            end
            OP_SUB:
            begin
                next_rsp.sat = dif_s[16] ^ dif_s[15];
                next_rsp.res_s = next_rsp.sat ? (dif_s[16] ? S_MIN : S_MAX)
                                              : dif_s[15:0];
            end
            OP_MULT:
            begin
                next_rsp.sat = both_min;
                next_rsp.res_s = both_min ? S_MAX : prod[30:SCALE_SH];
            end
            OP_MULT_R:
            begin
                next_rsp.sat = both_min;
                next_rsp.res_s = both_min ? S_MAX : prod_r[30:SCALE_SH];
            end
            OP_ABS:
            begin
                next_rsp.sat = (req.a_s == S_MIN);
                if (req.a_s == S_MIN)
                    next_rsp.res_s = S_MAX;
                else
                    next_rsp.res_s = req.a_s[15] ? 16'(~req.a_s + 16'h0001) : req.a_s;
            end
            OP_DIV:
            begin
                next_rsp.div_err = div_bad;
                next_rsp.res_s = quo;
            end
            OP_L_MULT:
            begin
                next_rsp.sat = both_min;
                next_rsp.res_l = both_min ? L_MAX : {prod[30:0], 1'b0};
            end
            OP_L_ADD:
            begin
                next_rsp.sat = sum_l[32] ^ sum_l[31];
                next_rsp.res_l = next_rsp.sat ? (sum_l[32] ? L_MIN : L_MAX)
                                              : sum_l[31:0];
            end
            OP_L_SUB:
            begin
                next_rsp.sat = dif_l[32] ^ dif_l[31];
                next_rsp.res_l = next_rsp.sat ? (dif_l[32] ? L_MIN : L_MAX)
                                              : dif_l[31:0];
            end
            OP_NORM: next_rsp.res_s = norm_cnt;
            OP_SHL: next_rsp.res_s = sh16(req.a_s, req.b_s, 1'b1);
            OP_SHR: next_rsp.res_s = sh16(req.a_s, req.b_s, 1'b0);
            OP_L_SHL: next_rsp.res_l = sh32(req.a_l, req.b_s, 1'b1);
            OP_L_SHR: next_rsp.res_l = sh32(req.a_l, req.b_s, 1'b0);
            OP_S_TO_L: next_rsp.res_l = {{16{req.a_s[15]}}, req.a_s};
            OP_L_TO_S: next_rsp.res_s = req.a_l[15:0];
            OP_MASK_SMP: next_rsp.res_s = req.a_s & SMP_MASK;
            OP_MASK_PAR: next_rsp.res_s = req.a_s & par_mask;
            default: next_rsp.res_s = 16'h0000;
        endcase
        // short results also appear sign-extended on the long lane
        case (req.op)
            OP_L_MULT, OP_L_ADD, OP_L_SUB, OP_L_SHL, OP_L_SHR, OP_S_TO_L:
                next_rsp.res_s = next_rsp.res_l[15:0];
            default:
                next_rsp.res_l = {{16{next_rsp.res_s[15]}}, next_rsp.res_s};
        endcase
    end

    // answer register
    always_ff @(posedge mclk)
    begin
        if (reset)
            rsp <= '0;
        else
            rsp <= next_rsp;
    end

    // checks on the answer against the request one cycle earlier
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    logic [15:0] h_sum_s;
    logic [15:0] h_dif_s;
    logic [31:0] h_sum_l;
    logic [31:0] h_dif_l;
    assign h_sum_s = 16'(req.a_s + req.b_s);
    assign h_dif_s = 16'(req.a_s - req.b_s);
    assign h_sum_l = 32'(req.a_l + b_eff);
    assign h_dif_l = 32'(req.a_l - b_eff);

    a_answer_latency: assert property (!$past(reset) |-> rsp.valid == $past(req.valid))
        else $error("answer valid does not follow request by one cycle");
    a_answer_op: assert property (!$past(reset) |-> rsp.op == $past(req.op))
        else $error("answer operation does not follow request");
    a_reset_clear: assert property (disable iff (1'b0) reset |=> rsp == '0)
        else $error("answer not cleared by reset");
    a_add_pos_sat: assert property (req.valid && req.op == OP_ADD && !req.a_s[15]
        && !req.b_s[15] && h_sum_s[15] |=> rsp.res_s == S_MAX && rsp.sat)
        else $error("short sum did not clamp high");
    a_add_neg_sat: assert property (req.valid && req.op == OP_ADD && req.a_s[15]
        && req.b_s[15] && !h_sum_s[15] |=> rsp.res_s == S_MIN && rsp.sat)
        else $error("short sum did not clamp low");
    a_sub_neg_sat: assert property (req.valid && req.op == OP_SUB && req.a_s[15]
        && !req.b_s[15] && !h_dif_s[15] |=> rsp.res_s == S_MIN && rsp.sat)
        else $error("short difference did not clamp low");
    a_sub_pos_sat: assert property (req.valid && req.op == OP_SUB && !req.a_s[15]
        && req.b_s[15] && h_dif_s[15] |=> rsp.res_s == S_MAX && rsp.sat)
        else $error("short difference did not clamp high");
    a_mult_corner: assert property (req.valid && req.op inside {OP_MULT, OP_MULT_R}
        && both_min |=> rsp.res_s == S_MAX)
        else $error("scaled product corner not 32767");
    a_mult_scaled: assert property (req.valid && req.op == OP_MULT && !both_min
        |=> rsp.res_s == 16'((32'($signed($past(req.a_s))) * 32'($signed($past(req.b_s))))
        >>> SCALE_SH))
        else $error("scaled product wrong");
    a_abs_min: assert property (req.valid && req.op == OP_ABS && req.a_s == S_MIN
        |=> rsp.res_s == S_MAX)
        else $error("magnitude of most negative not 32767");
    a_div_equal: assert property (req.valid && req.op == OP_DIV && !req.a_s[15]
        && req.a_s != 16'h0000 && req.a_s == req.b_s |=> rsp.res_s == S_MAX && !rsp.div_err)
        else $error("divide of equal operands not 32767");
    a_div_refuse: assert property (req.valid && req.op == OP_DIV && !req.b_s[15]
        && req.b_s < req.a_s |=> rsp.div_err && rsp.res_s == 16'h0000)
        else $error("divide with divisor below dividend not refused");
    a_lmult_value: assert property (req.valid && req.op == OP_L_MULT && !both_min
        |=> rsp.res_l == 32'((32'($signed($past(req.a_s))) * 32'($signed($past(req.b_s))))
        <<< 1))
        else $error("widening product wrong");
    a_lmult_corner: assert property (req.valid && req.op == OP_L_MULT && both_min
        |=> rsp.res_l == L_MAX && rsp.sat)
        else $error("widening product corner not clamped");
    a_ladd_sat: assert property (req.valid && req.op == OP_L_ADD && !req.a_l[31]
        && !b_eff[31] && h_sum_l[31] |=> rsp.res_l == L_MAX)
        else $error("long sum did not clamp high");
    a_lsub_sat: assert property (req.valid && req.op == OP_L_SUB && req.a_l[31]
        && !b_eff[31] && !h_dif_l[31] |=> rsp.res_l == L_MIN)
        else $error("long difference did not clamp low");
    a_norm_range: assert property (req.valid && req.op == OP_NORM && !req.a_l[31]
        && req.a_l != 32'h00000000 |=> rsp.res_s <= NORM_TOP
        && (32'($past(req.a_l) << rsp.res_s[4:0]) >= L_POS_LO))
        else $error("normalised value out of range");
    a_norm_neg: assert property (req.valid && req.op == OP_NORM && req.a_l[31]
        |=> rsp.res_s <= NORM_TOP
        && $signed(32'($past(req.a_l) << rsp.res_s[4:0])) <= $signed(L_NEG_HI)
        && (rsp.res_s == 16'h0000 || $signed(L_NEG_HI) < $signed(32'($past(req.a_l) << (rsp.res_s[4:0] - 5'h01)))))
        else $error("normalised negative value out of range");
    a_deposit_ext: assert property (req.valid && req.op == OP_S_TO_L
        |=> rsp.res_l == {{16{$past(req.a_s[15])}}, $past(req.a_s)})
        else $error("short to long not sign-extended");
    a_extract_low: assert property (req.valid && req.op == OP_L_TO_S
        |=> rsp.res_s == $past(req.a_l[15:0]))
        else $error("long to short not low half");
    a_mask_sample: assert property (req.valid && req.op == OP_MASK_SMP
        |=> rsp.res_s[2:0] == 3'h0 && rsp.res_s[15:3] == $past(req.a_s[15:3]))
        else $error("sample mask wrong");
    a_mask_param: assert property (req.valid && req.op == OP_MASK_PAR
        && req.param_w >= 3'h2 |=> (rsp.res_s >> $past(req.param_w)) == 16'h0000)
        else $error("parameter mask kept invalid upper bits");
    a_shl_neg: assert property (req.valid && req.op == OP_SHL && req.b_s == 16'hffff
        |=> rsp.res_s == {$past(req.a_s[15]), $past(req.a_s[15:1])})
        else $error("negative left shift not arithmetic right");
    a_lshr_sign: assert property (req.valid && req.op == OP_L_SHR && !req.b_s[15]
        && req.b_s >= SH_LIM_L |=> rsp.res_l == {32{$past(req.a_l[31])}})
        else $error("long right shift past width not sign filled");
    a_short_lane: assert property (req.valid && req.op == OP_SUB
        |=> rsp.res_l == {{16{rsp.res_s[15]}}, rsp.res_s})
        else $error("short result not sign-extended on long lane");

    c_add_sat: cover property (req.valid && req.op == OP_ADD ##1 rsp.sat);
    c_div_ok: cover property (req.valid && req.op == OP_DIV ##1 !rsp.div_err);
    c_norm_neg: cover property (req.valid && req.op == OP_NORM && req.a_l[31]);
    c_mult_corner: cover property (req.valid && req.op == OP_MULT_R && both_min);
    c_lmult_corner: cover property (req.valid && req.op == OP_L_MULT && both_min ##1 rsp.sat);

endmodule

`default_nettype wire

/* logic/fca_pkg.sv */
// fixed-point arithmetic unit: shared types and constants
// assumes a single clock domain and a sequencer that drives one request per cycle
package fca_pkg;

    // operation select
    typedef enum logic [4:0] {
        OP_ADD = 5'h00,
        OP_SUB = 5'h01,
        OP_MULT = 5'h02,
        OP_MULT_R = 5'h03,
        OP_ABS = 5'h04,
        OP_DIV = 5'h05,
        OP_L_MULT = 5'h06,
        OP_L_ADD = 5'h07,
        OP_L_SUB = 5'h08,
        OP_NORM = 5'h09,
        OP_SHL = 5'h0a,
        OP_SHR = 5'h0b,
        OP_L_SHL = 5'h0c,
        OP_L_SHR = 5'h0d,
        OP_S_TO_L = 5'h0e,
        OP_L_TO_S = 5'h0f,
        OP_MASK_SMP = 5'h10,
        OP_MASK_PAR = 5'h11
    } fca_op_t;

    // request from the sequencer
    typedef struct packed {
        logic valid;
        fca_op_t op;
        logic b_const;
        logic [2:0] param_w;
        logic [15:0] a_s;
        logic [15:0] b_s;
        logic [31:0] a_l;
        logic [31:0] b_l;
    } fca_req_t;

    // answer, one cycle after the request
    typedef struct packed {
        logic valid;
        fca_op_t op;
        logic sat;
        logic div_err;
        logic [15:0] res_s;
        logic [31:0] res_l;
    } fca_rsp_t;

    localparam logic [15:0] S_MAX = 16'h7fff;
    localparam logic [15:0] S_MIN = 16'h8000;
    localparam logic [31:0] L_MAX = 32'h7fffffff;
    localparam logic [31:0] L_MIN = 32'h80000000;
    localparam logic [31:0] L_POS_LO = 32'h40000000;
    localparam logic [31:0] L_NEG_HI = 32'hc0000000;
    localparam logic [31:0] MULT_RND = 32'h00004000;
    localparam logic [15:0] SMP_MASK = 16'hfff8;
    localparam logic [15:0] SH_LIM_S = 16'h0010;
    localparam logic [15:0] SH_LIM_L = 16'h0020;
    localparam int SCALE_SH = 15;
    localparam int DIV_STEPS = 15;
    localparam logic [15:0] NORM_TOP = 16'h001e;

endpackage

/* logic/fca_div.sv */
// fixed-point arithmetic unit: fractional divider, restoring, fully combinational
// assumes the caller registers the quotient
`timescale 1ns/1ps
`default_nettype none

module fca_div
    import fca_pkg::*;
(
    input wire logic [15:0] num,
    input wire logic [15:0] den,
    output logic [15:0] quo,
    output logic bad
);

    logic [16:0] rem [0:DIV_STEPS];
    logic [DIV_STEPS-1:0] qbit;

    // precondition: 0 < num <= den, both positive
    assign bad = num[15] | den[15] | (num == 16'h0000) | (den < num);

    assign rem[0] = {1'b0, num};

    // one restoring step per quotient bit, msb first
    genvar k;
    generate
        for (k = 0; k < DIV_STEPS; k++)
        begin : g_step
            logic [16:0] dbl;
            assign dbl = {rem[k][15:0], 1'b0};
            assign qbit[DIV_STEPS-1-k] = (dbl >= {1'b0, den});
            assign rem[k+1] = qbit[DIV_STEPS-1-k] ? 17'(dbl - {1'b0, den}) : dbl;
        end
    endgenerate

    // leading bit zero; equal operands give all ones
    assign quo = bad ? 16'h0000 : {1'b0, qbit};

endmodule

`default_nettype wire

/* dv/fca_seq_model.sv */
// fixed-point unit partner: sequencer model issuing one request at a time
// assumes the unit answers at the mclk edge that takes the request
`timescale 1ns/1ps
`default_nettype none
module fca_seq_model
    import fca_pkg::*;
(
    input wire logic mclk,
    output fca_req_t req,
    input wire fca_rsp_t rsp
);
    // quiet until the first request
    initial
    begin
        req = '0;
    end

    // drive after the falling edge, hold through the taking edge, capture at the next
    // falling edge where the registered answer has settled
    task automatic issue(input fca_op_t op, input logic [15:0] as, input logic [15:0] bs,
        input logic [31:0] al, input logic [31:0] bl, input logic bc, input logic [2:0] pw,
        output fca_rsp_t r);
        @(negedge mclk);
        req = '{1'b1, op, bc, pw, as, bs, al, bl};
        @(posedge mclk);
        @(negedge mclk);
        r = rsp;
        // released operand lines carry the inverse and op is held, so a stale copy cannot pass for live data
        req = '{1'b0, op, ~bc, ~pw, ~as, ~bs, ~al, ~bl};
    endtask
endmodule
`default_nettype wire

/* dv/fca_alu_tb.sv */
// fixed-point unit testbench: directed scenarios per primitive, self-checking
// assumes fca_seq_model issues requests; expectations are worked out by hand
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module fca_alu_tb
    import fca_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    fca_req_t req;
    fca_rsp_t rsp;
    fca_rsp_t r;
    int checks = 0;
    int bad_count = 0;
    int cyc = 0;

    // 200 MHz clock
    always #2.5 mclk = ~mclk;

    fca_alu dut (.mclk(mclk), .reset(reset), .req(req), .rsp(rsp));
    fca_seq_model seq (.mclk(mclk), .req(req), .rsp(rsp));

    // one request through the sequencer, answer left in r
    task automatic go(input fca_op_t op, input logic [15:0] as, input logic [15:0] bs,
        input logic [31:0] al = '0, input logic [31:0] bl = '0, input logic bc = 1'b0,
        input logic [2:0] pw = 3'h0);
        seq.issue(op, as, bs, al, bl, bc, pw, r);
    endtask

    task automatic results;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // hang guard, far above the roughly 125 cycles the run needs
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            bad_count++;
            results();
        end
    end

    task automatic t_add_sub;
        go(OP_ADD, 16'h7fff, 16'h0001);
        `CHK("add pos", 16'h7fff, r.res_s);
        `CHK("add sat", 1'b1, r.sat);
        `CHK("add valid", 1'b1, r.valid);
        `CHK("add op", OP_ADD, r.op);
        go(OP_ADD, 16'h8000, 16'hffff);
        `CHK("add neg", 16'h8000, r.res_s);
        `CHK("add long", 32'hffff8000, r.res_l);
        go(OP_ADD, 16'hfffd, 16'h0004);
        `CHK("add fit", 16'h0001, r.res_s);
        `CHK("add nosat", 1'b0, r.sat);
        go(OP_SUB, 16'h8000, 16'h0001);
        `CHK("sub neg", 16'h8000, r.res_s);
        go(OP_SUB, 16'h7fff, 16'hffff);
        `CHK("sub pos", 16'h7fff, r.res_s);
        go(OP_SUB, 16'h0003, 16'h0005);
        `CHK("sub fit", 16'hfffe, r.res_s);
        @(negedge mclk);
        `CHK("idle valid", 1'b0, rsp.valid);
    endtask

    task automatic t_mult_abs;
        go(OP_MULT, 16'h8000, 16'h8000);
        `CHK("mult min", 16'h7fff, r.res_s);
        go(OP_MULT, 16'h4000, 16'h4000);
        `CHK("mult half", 16'h2000, r.res_s);
        go(OP_MULT, 16'hffff, 16'h0001);
        `CHK("mult neg", 16'hffff, r.res_s);
        go(OP_MULT_R, 16'h8000, 16'h8000);
        `CHK("multr min", 16'h7fff, r.res_s);
        go(OP_MULT_R, 16'hffff, 16'h0001);
        `CHK("multr neg", 16'h0000, r.res_s);
        go(OP_MULT_R, 16'h0001, 16'h4000);
        `CHK("multr up", 16'h0001, r.res_s);
        go(OP_ABS, 16'h8000, 16'h0000);
        `CHK("abs min", 16'h7fff, r.res_s);
        go(OP_ABS, 16'hfffb, 16'h0000);
        `CHK("abs neg", 16'h0005, r.res_s);
    endtask

    task automatic t_div;
        go(OP_DIV, 16'h0001, 16'h0003);
        `CHK("div third", 16'h2aaa, r.res_s);
        go(OP_DIV, 16'h0005, 16'h0005);
        `CHK("div equal", 16'h7fff, r.res_s);
        go(OP_DIV, 16'h0001, 16'h0002);
        `CHK("div half", 16'h4000, r.res_s);
        `CHK("div ok", 1'b0, r.div_err);
        go(OP_DIV, 16'h0006, 16'h0005);
        `CHK("div big", 1'b1, r.div_err);
        `CHK("div big res", 16'h0000, r.res_s);
        go(OP_DIV, 16'h0000, 16'h0005);
        `CHK("div zero", 1'b1, r.div_err);
    endtask

    task automatic t_long;
        go(OP_L_MULT, 16'h0003, 16'hfffc);
        `CHK("lmult", 32'hffffffe8, r.res_l);
        go(OP_L_MULT, 16'h8000, 16'h0001);
        `CHK("lmult min", 32'hffff0000, r.res_l);
        go(OP_L_MULT, 16'h8000, 16'h8000);
        `CHK("lmult corner", 32'h7fffffff, r.res_l);
        `CHK("lmult sat", 1'b1, r.sat);
        `CHK("lmult low", 16'hffff, r.res_s);
        go(OP_L_ADD, 16'h0, 16'h0, 32'h7fffffff, 32'h00000001);
        `CHK("ladd pos", 32'h7fffffff, r.res_l);
        `CHK("ladd sat", 1'b1, r.sat);
        go(OP_L_ADD, 16'h0, 16'h0, 32'h80000000, 32'hffffffff);
        `CHK("ladd neg", 32'h80000000, r.res_l);
        go(OP_L_SUB, 16'h0, 16'h0, 32'h80000000, 32'h00000001);
        `CHK("lsub neg", 32'h80000000, r.res_l);
        go(OP_L_SUB, 16'h0, 16'h0, 32'h7fffffff, 32'hffffffff);
        `CHK("lsub pos", 32'h7fffffff, r.res_l);
        go(OP_L_ADD, 16'h0, 16'hffff, 32'h00000005, 32'h0, 1'b1);
        `CHK("ladd const", 32'h00000004, r.res_l);
        go(OP_L_SUB, 16'h0, 16'h8000, 32'h0, 32'h0, 1'b1);
        `CHK("lsub const", 32'h00008000, r.res_l);
    endtask

    task automatic t_norm_shift;
        logic [31:0] nv [6] = '{32'h1, 32'h40000000, 32'hffffffff, 32'hc0000000,
            32'he0000000, 32'h7fffffff};
        logic [15:0] ne [6] = '{16'h1e, 16'h0, 16'h1e, 16'h0, 16'h1, 16'h0};
        for (int i = 0; i < 6; i++)
        begin
            go(OP_NORM, 16'h0, 16'h0, nv[i]);
            `CHK("norm", ne[i], r.res_s);
        end
        go(OP_SHL, 16'h0001, 16'h0003);
        `CHK("shl", 16'h0008, r.res_s);
        go(OP_SHL, 16'h8000, 16'hfff1);
        `CHK("shl neg", 16'hffff, r.res_s);
        go(OP_SHR, 16'h8000, 16'h0003);
        `CHK("shr", 16'hf000, r.res_s);
        go(OP_SHR, 16'h0001, 16'hfffc);
        `CHK("shr neg", 16'h0010, r.res_s);
        go(OP_L_SHL, 16'h0, 16'h001f, 32'h1);
        `CHK("lshl", 32'h80000000, r.res_l);
        go(OP_L_SHL, 16'h0, 16'hfffe, 32'h80000000);
        `CHK("lshl neg", 32'he0000000, r.res_l);
        go(OP_L_SHR, 16'h0, 16'h001f, 32'h80000000);
        `CHK("lshr", 32'hffffffff, r.res_l);
        go(OP_L_SHR, 16'h0, 16'hfff8, 32'h00000001);
        `CHK("lshr neg", 32'h00000100, r.res_l);
        go(OP_L_SHR, 16'h0, 16'h0028, 32'h80000001);
        `CHK("lshr wide", 32'hffffffff, r.res_l);
    endtask

    task automatic t_conv;
        go(OP_S_TO_L, 16'h8001, 16'h0);
        `CHK("s to l neg", 32'hffff8001, r.res_l);
        go(OP_S_TO_L, 16'h7001, 16'h0);
        `CHK("s to l pos", 32'h00007001, r.res_l);
        go(OP_L_TO_S, 16'h0, 16'h0, 32'h12348765);
        `CHK("l to s", 16'h8765, r.res_s);
        go(OP_MASK_SMP, 16'hffff, 16'h0);
        `CHK("mask smp", 16'hfff8, r.res_s);
        for (int i = 2; i < 8; i++)
        begin
            go(OP_MASK_PAR, 16'hffff, 16'h0, 32'h0, 32'h0, 1'b0, 3'(i));
            `CHK("mask par", 16'((1 << i) - 1), r.res_s);
        end
        go(fca_op_t'(5'h1f), 16'h1234, 16'h0);
        `CHK("no op", 32'h00000000, r.res_l);
    endtask

    // reset in mid-run swallows a request and leaves nothing behind
    task automatic t_reset;
        @(negedge mclk);
        reset = 1'b1;
        go(OP_ADD, 16'h7fff, 16'h0001);
        `CHK("reset rsp", fca_rsp_t'(0), r);
        reset = 1'b0;
        go(OP_SUB, 16'h0003, 16'h0005);
        `CHK("after reset", 16'hfffe, r.res_s);
    endtask

    // reset held 8 cycles, then every scenario in turn
    initial
    begin
        repeat (8) @(negedge mclk);
        `CHK("rsp reset", fca_rsp_t'(0), rsp);
        reset = 1'b0;
        t_add_sub();
        t_mult_abs();
        t_div();
        t_long();
        t_norm_shift();
        t_conv();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
